//--- smpc_checker.sv
// Purpose: port-level checks of the protection controller
// Assumes: single ref_clk domain, rst_n synchronous active low
// Notes: windows allow for the three-flop synchroniser
module smpc_checker #(
   parameter int BLANK_CYC = 1,
   parameter int IGNORE_CYC = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Comparators and power stage
   input wire smpc_pkg::smpc_cmp_s cmpIn,
   input wire smpc_pkg::smpc_pwr_s pwrOut,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Interrupt
   input wire logic irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic rdReq;
   assign rdReq = hsel && (htrans == smpc_pkg::HTRANS_NONSEQ) && !hwrite && hready;

   a_reset_values:
   assert property (disable iff (1'b0) !rst_n |=> (pwrOut == smpc_pkg::PWR_RST) && !irq)
      else $error("outputs wrong under reset");
   a_cs_not_early:
   assert property ($rose(cmpIn.csPeak) && pwrOut.switchEnable |=> pwrOut.switchEnable [*2])
      else $error("peak latch acted before synchronising");
   a_cs_latch_fast:
   assert property ($rose(cmpIn.csPeak) && pwrOut.switchEnable |-> ##[3:7] !pwrOut.switchEnable && !pwrOut.refEnable)
      else $error("peak latch too slow");
   a_cell_on_low:
   assert property ($rose(cmpIn.vccUnder) ##1 cmpIn.vccUnder [*7] |-> ##[0:6] pwrOut.startupCellOn)
      else $error("startup cell not on at low supply");
   a_cell_off_high:
   assert property ($rose(cmpIn.vccOn) ##1 cmpIn.vccOn [*7] |-> ##[0:6] !pwrOut.startupCellOn)
      else $error("startup cell not off at high supply");
   a_deep_drop_clears:
   assert property ($rose(cmpIn.vccReset) ##1 cmpIn.vccReset [*7] |-> ##[0:6] pwrOut.refEnable && !pwrOut.switchEnable)
      else $error("deep supply drop did not restart");
   a_bus_okay:
   assert property (hreadyout && (hresp == 1'b0))
      else $error("bus not ready or not okay");
   a_rdata_holds:
   assert property (!$past(rdReq) |-> $stable(hrdata))
      else $error("read data changed without a read");

   c_cs_latch: cover property ($rose(cmpIn.csPeak) && pwrOut.switchEnable);
   c_clamp_release: cover property ($fell(pwrOut.clampHold));
   c_irq_rise: cover property ($rose(irq));
endmodule // smpc_checker

bind smpc_top smpc_checker #(.BLANK_CYC(BLANK_CYC), .IGNORE_CYC(IGNORE_CYC)) u_smpc_checker (.ref_clk(ref_clk),
   .rst_n(rst_n), .cmpIn(cmpIn), .pwrOut(pwrOut), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

//--- smpc_cmp_model.sv
// Purpose: comparator front end seen by the protection controller
// Assumes: analog levels given in millivolts by the bench
// Notes: delay pin sits at its clamp while clampHold is high
module smpc_cmp_model (
   // Analog levels
   input wire logic signed [31:0] vccMv,
   input wire logic signed [31:0] fbMv,
   input wire logic signed [31:0] csMv,
   input wire logic signed [31:0] blMv,
   input wire logic hot,
   // Clamp control from the controller
   input wire logic clampHold,
   // Comparator flags
   output smpc_pkg::smpc_cmp_s cmpOut
);
   assign cmpOut.vccOver = (vccMv > 24000);
   assign cmpOut.fbHigh = (fbMv > 4500);
   assign cmpOut.overTemp = hot;
   assign cmpOut.csPeak = (csMv > 1660);
   // External pulldown beats the clamp
   assign cmpOut.delayPinLow = (blMv < 100);
   // No capacitor: threshold reached as soon as released
   assign cmpOut.delayPinThresh = !clampHold && (blMv >= 4000);
   assign cmpOut.vccUnder = (vccMv < 10500);
   assign cmpOut.vccOn = (vccMv > 18000);
   assign cmpOut.vccReset = (vccMv < 6230);
endmodule // smpc_cmp_model

//--- smpc_pkg.sv
// Purpose: shared constants and types of the protection mode controller
// Assumes: 20 MHz ref_clk, 32-bit AHB-Lite register access
// Notes: every count below is derived from a time and the clock period
package smpc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SPIKE_NS = 8000;
   localparam int BLANK_NS = 20000000;
   localparam int IGNORE_NS = 1000000;
   // Least times, rounded up
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IGNORE_CYC = (IGNORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 20;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   // Status fields
   localparam int ST_MODE_LSB = 0;
   localparam int ST_PWR_LSB = 4;
   localparam int ST_CMP_LSB = 8;

   // Interrupt bits
   localparam int IRQ_W = 4;
   localparam int IRQ_LATCH = 0;
   localparam int IRQ_RESTART = 1;
   localparam int IRQ_BLANK = 2;
   localparam int IRQ_RELEASE = 3;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   localparam logic [3:0] IRQ_STAT_RST = 4'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SMPC_CHARGE = 3'b000,
      SMPC_RUN = 3'b001,
      SMPC_RESTART = 3'b010,
      SMPC_LATCHED = 3'b011
   } smpc_mode_e;

   // Comparator flags, all active high
   typedef struct packed {
      logic vccOver;        // Supply above 24 V
      logic fbHigh;         // Feedback above 4.5 V
      logic overTemp;       // Junction above thermal trip
      logic csPeak;         // Current-sense peak above 1.66 V
      logic delayPinLow;    // Delay pin below 0.1 V
      logic delayPinThresh; // Delay pin at or above 4.0 V
      logic vccUnder;       // Supply below 10.5 V
      logic vccOn;          // Supply above 18 V
      logic vccReset;       // Supply below 6.23 V
   } smpc_cmp_s;

   typedef struct packed {
      logic startupCellOn;
      logic refEnable;
      logic switchEnable;
      logic clampHold;
   } smpc_pwr_s;

   localparam smpc_pwr_s PWR_RST = '{startupCellOn: 1'b1, refEnable: 1'b1,
                                     switchEnable: 1'b0, clampHold: 1'b1};

endpackage

//--- smpc_spike.sv
// Purpose: spike filter, output rises after input held high CYC cycles
// Assumes: input already synchronous
// Notes: output falls in the cycle after the input falls
module smpc_spike #(
   parameter int CYC = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Data
   input wire logic din,
   output logic dout
);

   localparam int CW = $clog2(CYC + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic q;
   } smpc_spike_s;

   smpc_spike_s st_r;
   smpc_spike_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!din) begin
         st_nxt.cnt = '0;
         st_nxt.q = 1'b0;
      end else if (st_r.cnt == CW'(CYC - 1)) begin
         st_nxt.q = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + CW'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.q;

endmodule // smpc_spike

//--- smpc_sync.sv
// Purpose: three-stage synchroniser with agreement check
// Assumes: inputs asynchronous to ref_clk
// Notes: a change is taken once stages two and three agree
module smpc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } smpc_sync_s;

   smpc_sync_s st_r;
   smpc_sync_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.q;

endmodule // smpc_sync

//--- smpc_top.sv
// Purpose: protection mode controller of an off-line switching supply
// Assumes: comparator flags arrive asynchronous, AHB-Lite single master
// Notes: selects charge, run, auto-restart and latched-off behaviour
//
// Overview of operation
// [RULE_01] Overvoltage counts only while supply above 24V and feedback above 4.5V.
// [RULE_02] Latched-off holds until supply drops below 6.23V; nothing else clears.
// [RULE_03] While latched, startup cell on below 10.5V, off above 18V.
// [RULE_04] Latched-off never starts a startup phase or switching again.
// [RULE_05] Latched-off turns the internal reference off.
// [RULE_06] Over-temperature enters latched-off.
// [RULE_07] Over-temperature and overvoltage pass an 8.0us spike filter first.
// [RULE_08] Current-sense peak above 1.66V latches off at once, unblanked.
// [RULE_09] Delay pin pulled low latches off, ignored for 1ms after start-up.
// [RULE_10] Feedback high runs the 20ms blanking counter, then releases the clamp.
// [RULE_11] Delay pin reaching 4.0V after release ends extended blanking.
// [RULE_12] Blanking done plus delay threshold enters auto-restart after 8.0us filter.
// [RULE_13] Supply undervoltage enters auto-restart and a new startup cycle.
// [RULE_14] Auto-restart always recharges, switches, rechecks faults, resumes normally.
// [RULE_15] Comparator inputs are synchronised; intervals are clock cycle counts.
module smpc_top #(
   parameter int BLANK_CYC = smpc_pkg::BLANK_CYC,
   parameter int IGNORE_CYC = smpc_pkg::IGNORE_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Comparator flags
   input wire smpc_pkg::smpc_cmp_s cmpIn,
   // Power stage controls
   output smpc_pkg::smpc_pwr_s pwrOut,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Interrupt
   output logic irq
);

   localparam int CW = smpc_pkg::CNT_W;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      smpc_pkg::smpc_mode_e mode;
      logic [CW-1:0] blankCnt;
      logic [CW-1:0] ignoreCnt;
      smpc_pkg::smpc_pwr_s pwr;
      logic [smpc_pkg::IRQ_W-1:0] irqStat;
      logic [smpc_pkg::IRQ_W-1:0] irqMask;
      logic irq;
      logic [31:0] rdData;
      logic readyOut;
      logic wrPend;
      logic [smpc_pkg::ADDR_W-1:0] wrAddr;
   } smpc_state_s;

   localparam smpc_state_s ST_RST = '{
      mode: smpc_pkg::SMPC_CHARGE,
      blankCnt: '0,
      ignoreCnt: '0,
      pwr: smpc_pkg::PWR_RST,
      irqStat: smpc_pkg::IRQ_STAT_RST,
      irqMask: smpc_pkg::IRQ_MASK_RST,
      irq: 1'b0,
      rdData: '0,
      readyOut: 1'b1,
      wrPend: 1'b0,
      wrAddr: '0
   };

   smpc_state_s st_r;
   smpc_state_s st_nxt;

   // ----------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------
   smpc_pkg::smpc_cmp_s cmpSync;
   logic ovpRaw;
   logic ovpFilt;
   logic otpFilt;
   logic restartRaw;
   logic restartFilt;
   logic blankDone;

   smpc_sync #(
      .W($bits(smpc_pkg::smpc_cmp_s))
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(cmpIn), // [RULE_15]
      .dout(cmpSync)
   );

   assign ovpRaw = cmpSync.vccOver & cmpSync.fbHigh; // [RULE_01]
   assign blankDone = (st_r.blankCnt >= CW'(BLANK_CYC));
   // No capacitor: threshold flag is already high at release
   assign restartRaw = (st_r.mode == smpc_pkg::SMPC_RUN) & blankDone & cmpSync.delayPinThresh; // [RULE_11]

   smpc_spike #(
      .CYC(smpc_pkg::SPIKE_CYC)
   ) u_ovp_filt (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(ovpRaw), // [RULE_07]
      .dout(ovpFilt)
   );

   smpc_spike #(
      .CYC(smpc_pkg::SPIKE_CYC)
   ) u_otp_filt (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(cmpSync.overTemp), // [RULE_07]
      .dout(otpFilt)
   );

   smpc_spike #(
      .CYC(smpc_pkg::SPIKE_CYC)
   ) u_restart_filt (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(restartRaw), // [RULE_12]
      .dout(restartFilt)
   );

   // ----------------------------------------------------------------
   // Mode control and bus
   // ----------------------------------------------------------------
   logic latchReq;
   logic extLatch;
   logic addrPhase;
   logic [smpc_pkg::IRQ_W-1:0] events;
   logic [31:0] rdMux;

   always_comb begin
      st_nxt = st_r;
      events = '0;
      rdMux = '0;

      // Delay pin pull-down only counts once start-up has settled
      extLatch = (st_r.mode == smpc_pkg::SMPC_RUN) && (st_r.ignoreCnt >= CW'(IGNORE_CYC))
                 && cmpSync.delayPinLow; // [RULE_09]
      latchReq = ovpFilt | otpFilt | cmpSync.csPeak | extLatch; // [RULE_06] [RULE_08]

      case (st_r.mode)
         smpc_pkg::SMPC_CHARGE: begin
            if (cmpSync.vccOn) begin
               st_nxt.mode = smpc_pkg::SMPC_RUN; // [RULE_14]
               st_nxt.ignoreCnt = '0;
               st_nxt.blankCnt = '0;
            end
         end
         smpc_pkg::SMPC_RUN: begin
            if (st_r.ignoreCnt < CW'(IGNORE_CYC)) begin
               st_nxt.ignoreCnt = st_r.ignoreCnt + CW'(1);
            end
            if (!cmpSync.fbHigh) begin
               st_nxt.blankCnt = '0;
            end else if (!blankDone) begin
               st_nxt.blankCnt = st_r.blankCnt + CW'(1); // [RULE_10]
            end
            if (cmpSync.fbHigh && st_r.blankCnt == CW'(BLANK_CYC - 1)) begin
               events[smpc_pkg::IRQ_BLANK] = 1'b1;
            end
            if (cmpSync.vccUnder || restartFilt) begin
               st_nxt.mode = smpc_pkg::SMPC_RESTART; // [RULE_12] [RULE_13]
               st_nxt.blankCnt = '0;
            end
         end
         smpc_pkg::SMPC_RESTART: begin
            // Supply decays without self-supply, then recharges
            if (cmpSync.vccUnder) begin
               st_nxt.mode = smpc_pkg::SMPC_CHARGE; // [RULE_13] [RULE_14]
            end
         end
         smpc_pkg::SMPC_LATCHED: begin
            st_nxt.mode = smpc_pkg::SMPC_LATCHED; // [RULE_04]
         end
         default: begin
            st_nxt.mode = smpc_pkg::SMPC_CHARGE;
         end
      endcase

      if (st_r.mode != smpc_pkg::SMPC_LATCHED && latchReq) begin
         st_nxt.mode = smpc_pkg::SMPC_LATCHED;
         st_nxt.blankCnt = '0;
      end

      // Deep supply drop is the only way out of latched-off
      if (cmpSync.vccReset) begin
         st_nxt.mode = smpc_pkg::SMPC_CHARGE; // [RULE_02]
         st_nxt.blankCnt = '0;
         st_nxt.ignoreCnt = '0;
      end

      if (st_nxt.mode == smpc_pkg::SMPC_LATCHED && st_r.mode != smpc_pkg::SMPC_LATCHED) begin
         events[smpc_pkg::IRQ_LATCH] = 1'b1;
      end
      if (st_nxt.mode == smpc_pkg::SMPC_RESTART && st_r.mode != smpc_pkg::SMPC_RESTART) begin
         events[smpc_pkg::IRQ_RESTART] = 1'b1;
      end
      if (st_nxt.mode != smpc_pkg::SMPC_LATCHED && st_r.mode == smpc_pkg::SMPC_LATCHED) begin
         events[smpc_pkg::IRQ_RELEASE] = 1'b1;
      end

      // Power stage controls follow the next mode
      st_nxt.pwr.switchEnable = (st_nxt.mode == smpc_pkg::SMPC_RUN); // [RULE_04]
      st_nxt.pwr.refEnable = (st_nxt.mode != smpc_pkg::SMPC_LATCHED); // [RULE_05]
      st_nxt.pwr.clampHold = !((st_nxt.mode == smpc_pkg::SMPC_RUN)
                               && (st_nxt.blankCnt >= CW'(BLANK_CYC))); // [RULE_10]
      case (st_nxt.mode)
         smpc_pkg::SMPC_CHARGE: begin
            st_nxt.pwr.startupCellOn = 1'b1;
         end
         smpc_pkg::SMPC_LATCHED: begin
            // Hysteresis gives the sawtooth supply
            if (cmpSync.vccUnder) begin
               st_nxt.pwr.startupCellOn = 1'b1; // [RULE_03]
            end else if (cmpSync.vccOn) begin
               st_nxt.pwr.startupCellOn = 1'b0; // [RULE_03]
            end
         end
         default: begin
            st_nxt.pwr.startupCellOn = 1'b0;
         end
      endcase

      // Bus data phase: write completes one cycle after its address
      if (st_r.wrPend) begin
         case (st_r.wrAddr)
            smpc_pkg::ADDR_IRQ_STAT: begin
               st_nxt.irqStat = st_r.irqStat & ~hwdata[smpc_pkg::IRQ_W-1:0];
            end
            smpc_pkg::ADDR_IRQ_MASK: begin
               st_nxt.irqMask = hwdata[smpc_pkg::IRQ_W-1:0];
            end
            default: begin
               st_nxt.irqStat = st_r.irqStat;
            end
         endcase
      end
      // A new event beats a simultaneous clear
      st_nxt.irqStat = st_nxt.irqStat | events;
      st_nxt.irq = |(st_nxt.irqStat & st_nxt.irqMask);

      // Bus address phase
      addrPhase = hsel && (htrans == smpc_pkg::HTRANS_NONSEQ) && hready;
      st_nxt.wrPend = addrPhase && hwrite;
      if (addrPhase) begin
         st_nxt.wrAddr = haddr[smpc_pkg::ADDR_W-1:0];
      end
      case (haddr[smpc_pkg::ADDR_W-1:0])
         smpc_pkg::ADDR_STATUS: begin
            rdMux[smpc_pkg::ST_MODE_LSB +: 3] = st_r.mode;
            rdMux[smpc_pkg::ST_PWR_LSB +: 4] = st_r.pwr;
            rdMux[smpc_pkg::ST_CMP_LSB +: 9] = cmpSync;
         end
         smpc_pkg::ADDR_IRQ_STAT: begin
            rdMux[smpc_pkg::IRQ_W-1:0] = st_r.irqStat;
         end
         smpc_pkg::ADDR_IRQ_MASK: begin
            rdMux[smpc_pkg::IRQ_W-1:0] = st_r.irqMask;
         end
         default: begin
            rdMux = '0;
         end
      endcase
      if (addrPhase && !hwrite) begin
         st_nxt.rdData = rdMux;
      end
      st_nxt.readyOut = 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign pwrOut = st_r.pwr;
   assign hreadyout = st_r.readyOut;
   assign hresp = 1'b0;
   assign hrdata = st_r.rdData;
   assign irq = st_r.irq;

endmodule // smpc_top

//--- smpc_top_bench.sv
// Purpose: self-checking bench of the protection controller
// Assumes: zero-wait AHB-Lite slave, shortened blanking counts
// Notes: modes read back through the status register
module smpc_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BLANK = 50;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   int vccMv = 0;
   int fbMv = 2000;
   int csMv = 500;
   int blMv = 4100;
   logic hot = 1'b0;
   smpc_pkg::smpc_cmp_s cmpIn;
   smpc_pkg::smpc_pwr_s pwrOut;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, irq;
   logic [31:0] hrdata, rd;
   int failures = 0;
   int checks = 0;

   always #25 ref_clk = ~ref_clk;

   smpc_cmp_model u_smpc_cmp_model (.vccMv(vccMv), .fbMv(fbMv), .csMv(csMv), .blMv(blMv), .hot(hot),
      .clampHold(pwrOut.clampHold), .cmpOut(cmpIn));
   smpc_top #(.BLANK_CYC(BLANK), .IGNORE_CYC(20)) u_smpc_top (.ref_clk(ref_clk), .rst_n(rst_n), .cmpIn(cmpIn),
      .pwrOut(pwrOut), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bounded wait for hready sampled high
   task bus_wait;
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         failures++;
         test_done;
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= smpc_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      bus_wait;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      bus_wait;
      rd = hrdata;
   endtask

   // Polls the mode field, bounded
   task mode(input logic [2:0] m);
      int n;
      n = 0;
      do begin
         bus(1'b0, smpc_pkg::ADDR_STATUS, 32'h0);
         n++;
      end while (rd[2:0] !== m && n < 200);
      check({29'h0, rd[2:0]}, {29'h0, m});
      // Poll ran out: report at once
      if (rd[2:0] !== m) test_done;
   endtask

   task idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      idle(4);
      rst_n <= 1'b1;
      idle(1);
      check(32'(pwrOut), 32'(smpc_pkg::PWR_RST));
      bus(1'b0, smpc_pkg::ADDR_IRQ_MASK, 32'h0);
      check(rd, {28'h0, smpc_pkg::IRQ_MASK_RST});
      bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
      bus(1'b0, 8'h0C, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, smpc_pkg::ADDR_STATUS, 32'h3);
      mode(smpc_pkg::SMPC_CHARGE);
      bus(1'b1, smpc_pkg::ADDR_IRQ_MASK, 32'hF);
      bus(1'b0, smpc_pkg::ADDR_IRQ_MASK, 32'h0);
      check(rd, 32'hF);
      vccMv <= 19000;
      mode(smpc_pkg::SMPC_RUN);
      blMv <= 50;
      idle(8);
      blMv <= 4100;
      idle(40);
      mode(smpc_pkg::SMPC_RUN);
      hot <= 1'b1;
      idle(100);
      hot <= 1'b0;
      vccMv <= 25000;
      idle(300);
      vccMv <= 19000;
      mode(smpc_pkg::SMPC_RUN);
      blMv <= 900;
      fbMv <= 4800;
      idle(BLANK - 8);
      check(32'(pwrOut.clampHold), 32'h1);
      idle(30);
      check(32'(pwrOut.clampHold), 32'h0);
      idle(300);
      mode(smpc_pkg::SMPC_RUN);
      blMv <= 4100;
      idle(100);
      mode(smpc_pkg::SMPC_RUN);
      idle(100);
      mode(smpc_pkg::SMPC_RESTART);
      bus(1'b0, smpc_pkg::ADDR_IRQ_STAT, 32'h0);
      check(rd, 32'h6);
      check(32'(irq), 32'h1);
      bus(1'b1, smpc_pkg::ADDR_IRQ_MASK, 32'h1);
      idle(2);
      check(32'(irq), 32'h0);
      bus(1'b1, smpc_pkg::ADDR_IRQ_STAT, 32'h6);
      bus(1'b0, smpc_pkg::ADDR_IRQ_STAT, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, smpc_pkg::ADDR_IRQ_MASK, 32'hF);
      fbMv <= 2000;
      vccMv <= 10000;
      mode(smpc_pkg::SMPC_CHARGE);
      vccMv <= 19000;
      mode(smpc_pkg::SMPC_RUN);
      vccMv <= 10000;
      mode(smpc_pkg::SMPC_CHARGE);
      vccMv <= 19000;
      mode(smpc_pkg::SMPC_RUN);
      idle(40);
      blMv <= 50;
      mode(smpc_pkg::SMPC_LATCHED);
      check(32'(pwrOut.refEnable), 32'h0);
      blMv <= 4100;
      vccMv <= 10000;
      idle(20);
      check(32'(pwrOut.startupCellOn), 32'h1);
      vccMv <= 19000;
      idle(20);
      check(32'(pwrOut.startupCellOn), 32'h0);
      check(32'(pwrOut.switchEnable), 32'h0);
      vccMv <= 7000;
      idle(20);
      mode(smpc_pkg::SMPC_LATCHED);
      vccMv <= 5000;
      mode(smpc_pkg::SMPC_CHARGE);
      bus(1'b0, smpc_pkg::ADDR_IRQ_STAT, 32'h0);
      check(rd, 32'hB);
      for (int k = 0; k < 3; k++) begin
         vccMv <= 19000;
         mode(smpc_pkg::SMPC_RUN);
         idle(40);
         if (k == 0) csMv <= 1700;
         else if (k == 1) hot <= 1'b1;
         else begin
            vccMv <= 25000;
            fbMv <= 4800;
         end
         mode(smpc_pkg::SMPC_LATCHED);
         csMv <= 500;
         hot <= 1'b0;
         fbMv <= 2000;
         vccMv <= 5000;
         mode(smpc_pkg::SMPC_CHARGE);
      end
      test_done;
   end

   // Hang guard
   initial begin
      idle(100000);
      failures++;
      test_done;
   end
endmodule // smpc_top_bench
